// >>> logic/dpv_pkg.sv
// constants, offsets and helper functions for the dscp map and pvid insert block
package dpv_pkg;

  // register port widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [7:0] OFS_MAP_52 = 8'h9d;
  localparam logic [7:0] OFS_MAP_56 = 8'h9e;
  localparam logic [7:0] OFS_MAP_60 = 8'h9f;
  localparam logic [7:0] OFS_RSVD_B0 = 8'hb0;
  localparam logic [3:0][7:0] OFS_PORT_CTRL = {8'hf0, 8'he0, 8'hd0, 8'hc0};

  // values after reset
  localparam logic [7:0] RST_MAP = 8'h00;
  localparam logic [2:0] RST_INS = 3'h0;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // field positions in a port control register
  localparam int unsigned BIT_INS_HIGH = 3;
  localparam int unsigned BIT_INS_2HIGH = 2;
  localparam int unsigned BIT_INS_2LOW = 1;

  // map geometry
  localparam int unsigned NUM_PORTS = 4;
  localparam int unsigned MAP_BITS = 128;
  localparam int unsigned LOWER_MAP_BITS = 104;
  localparam int unsigned UPPER_MAP_BITS = 24;
  localparam int unsigned PRIO_W = 2;
  localparam int unsigned TOS_DSCP_LSB = 2;

  // 2-bit priority field of one code point in the concatenated map
  function automatic logic [1:0] dscp_field(input logic [127:0] map,
                                            input logic [5:0] cp);
    return map[{cp, 1'b0} +: 2];
  endfunction

  // true when dst is an egress enabled by en = {high, 2nd high, 2nd low}
  // for the 0-based source port src
  function automatic logic insert_hit(input logic [1:0] src,
                                      input logic [1:0] dst,
                                      input logic [2:0] en);
    logic [1:0] hi;
    logic [1:0] shi;
    logic [1:0] slo;
    hi = 2'h3;
    shi = 2'h2;
    slo = 2'h1;
    unique case (src)
      2'h0: begin
        hi = 2'h3;
        shi = 2'h2;
        slo = 2'h1;
      end
      2'h1: begin
        hi = 2'h3;
        shi = 2'h2;
        slo = 2'h0;
      end
      2'h2: begin
        hi = 2'h3;
        shi = 2'h1;
        slo = 2'h0;
      end
      2'h3: begin
        hi = 2'h2;
        shi = 2'h1;
        slo = 2'h0;
      end
    endcase
    return (en[2] && dst == hi) || (en[1] && dst == shi) ||
           (en[0] && dst == slo);
  endfunction

endpackage

// >>> logic/dpv_cfg_if.sv
// configuration carried from the register file to the two decision units
`timescale 1ns/1ps
`default_nettype none
interface dpv_cfg_if;
  import dpv_pkg::*;
  logic [23:0] dscp_upper;  // code points 0x34..0x3f, two bits each
  logic [11:0] ins_en;      // per port {high, 2nd high, 2nd low}
  logic global_en;          // global pvid insertion enable
  modport src (output dscp_upper, output ins_en, output global_en);
  modport cls (input dscp_upper);
  modport pvid (input ins_en, input global_en);
endinterface
`default_nettype wire

// >>> logic/dpv_dscp_class.sv
// dscp to priority classifier for ipv4 and ipv6 packets
`timescale 1ns/1ps
`default_nettype none
module dpv_dscp_class
  import dpv_pkg::*;
(
  input wire logic clk,                  // system clock
  input wire logic rst_n,                // synchronised reset
  dpv_cfg_if.cls cfg,                    // upper map fields
  input wire logic [103:0] lower_map,    // code points 0x00..0x33
  input wire logic pkt_valid,            // tos byte present
  input wire logic [7:0] pkt_tos,        // tos or traffic class byte
  output logic [1:0] prio_reg,           // selected priority
  output logic prio_valid_reg            // priority valid pulse
);

  logic [127:0] full_map;
  logic [5:0] code_point;

  // both ip versions share one map; dscp is the top six bits
  assign full_map = {cfg.dscp_upper, lower_map};
  assign code_point = pkt_tos[7:TOS_DSCP_LSB];

  // one cycle lookup, held until the next packet
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prio_reg <= 2'h0;
      prio_valid_reg <= 1'b0;
    end else begin
      prio_valid_reg <= pkt_valid;
      if (pkt_valid) begin
        prio_reg <= dscp_field(full_map, code_point);
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_prio_lookup: assert property (
    pkt_valid |=> prio_valid_reg &&
      prio_reg == dscp_field($past(full_map), $past(code_point)))
    else $error("priority differs from map field");

  a_prio_hold: assert property (
    !pkt_valid |=> !prio_valid_reg && $stable(prio_reg))
    else $error("priority moved without a packet");

endmodule
`default_nettype wire

// >>> logic/dpv_pvid_sel.sv
// decides whether an untagged frame gets the source port pvid at egress
`timescale 1ns/1ps
`default_nettype none
module dpv_pvid_sel
  import dpv_pkg::*;
(
  input wire logic clk,               // system clock
  input wire logic rst_n,             // synchronised reset
  dpv_cfg_if.pvid cfg,                // per port insert enables
  input wire logic frm_valid,         // frame decision request
  input wire logic frm_untagged,      // frame arrived without tag
  input wire logic [1:0] frm_src,     // source port, 0 is port 1
  input wire logic [1:0] frm_dst,     // egress port, 0 is port 1
  output logic insert_reg,            // insert source pvid
  output logic done_reg               // decision valid pulse
);

  logic [2:0] src_en;
  logic hit;

  assign src_en = cfg.ins_en[{frm_src, 2'b00} - {2'b00, frm_src} +: 3];
  // tagged frames keep their own tag; global bit gates everything
  assign hit = frm_untagged && cfg.global_en &&
               insert_hit(frm_src, frm_dst, src_en);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      insert_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= frm_valid;
      if (frm_valid) begin
        insert_reg <= hit;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_global_gate: assert property (
    frm_valid && !cfg.global_en |=> done_reg && !insert_reg)
    else $error("insertion without global enable");

  a_insert_high: assert property (
    frm_valid && frm_untagged && cfg.global_en && src_en[2] &&
      frm_dst == ((frm_src == 2'h3) ? 2'h2 : 2'h3)
      |=> insert_reg)
    else $error("highest egress insertion missed");

  a_insert_2high: assert property (
    frm_valid && frm_untagged && cfg.global_en && src_en[1] &&
      frm_dst == ((frm_src < 2'h2) ? 2'h2 : 2'h1)
      |=> insert_reg)
    else $error("second highest egress insertion missed");

  a_insert_2low: assert property (
    frm_valid && frm_untagged && cfg.global_en && src_en[0] &&
      frm_dst == ((frm_src == 2'h0) ? 2'h1 : 2'h0)
      |=> insert_reg)
    else $error("second lowest egress insertion missed");

  a_tagged_keep: assert property (
    frm_valid && !frm_untagged |=> !insert_reg)
    else $error("tagged frame got pvid");

  a_no_enable: assert property (
    frm_valid && src_en == 3'h0 |=> !insert_reg)
    else $error("insertion with all port bits clear");

endmodule
`default_nettype wire

// >>> logic/dpv_top.sv
// dscp upper map and per port pvid insert registers with their decision units
//
// Notes on behaviour
// - register 0x9d holds 2-bit priorities for dscp 0x34..0x37, reset 00
// - register 0x9e holds 2-bit priorities for dscp 0x38..0x3b, reset 00
// - register 0x9f holds 2-bit priorities for dscp 0x3c..0x3f, reset 00
// - ipv4 and ipv6 share one concatenated map, two bits per code point
// - port control registers at 0xc0..0xf0; bits 7-4 read zero
// - bit 3 inserts pvid for untagged frames to the highest other egress
// - bit 2 inserts pvid for untagged frames to second highest egress
// - insertion bits act only while the global enable bit is set
// - bit 1 inserts pvid at second lowest egress; bit 0 reads zero
`timescale 1ns/1ps
`default_nettype none
module dpv_top
  import dpv_pkg::*;
(
  input wire logic CLOCK,                   // 125 mhz system clock
  input wire logic ARST_N,                  // async reset, active low
  input wire logic REG_WR,                  // register write strobe
  input wire logic REG_RD,                  // register read strobe
  input wire logic [7:0] REG_ADDR,          // register offset
  input wire logic [7:0] REG_WDATA,         // write data
  output logic [7:0] REG_RDATA,             // read data
  output logic REG_RVALID,                  // read data valid pulse
  input wire logic GLOBAL_PVID_EN,          // global insertion enable bit
  input wire logic [103:0] LOWER_DSCP_MAP,  // map fields 0x00..0x33
  input wire logic PKT_VALID,               // classify request
  input wire logic [7:0] PKT_TOS,           // tos or traffic class byte
  output logic [1:0] PKT_PRIO,              // packet priority
  output logic PKT_PRIO_VALID,              // priority valid pulse
  input wire logic FRM_VALID,               // egress decision request
  input wire logic FRM_UNTAGGED,            // frame has no vlan tag
  input wire logic [1:0] FRM_SRC_PORT,      // source port, 0 is port 1
  input wire logic [1:0] FRM_DST_PORT,      // egress port, 0 is port 1
  output logic FRM_INSERT_PVID,             // insert source pvid
  output logic FRM_DONE                     // decision valid pulse
);

  logic rst_meta_reg;
  logic rst_n;
  logic [7:0] map52_reg;
  logic [7:0] map56_reg;
  logic [7:0] map60_reg;
  logic [3:0][2:0] ins_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic wr_map52;
  logic wr_map56;
  logic wr_map60;
  logic [3:0] wr_ctrl;

  dpv_cfg_if cfg ();

  // reset enters asynchronously but is released on the clock, so no
  // register sees a release in the middle of a setup window
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // address decode of the writable registers
  assign wr_map52 = REG_WR && REG_ADDR == OFS_MAP_52;
  assign wr_map56 = REG_WR && REG_ADDR == OFS_MAP_56;
  assign wr_map60 = REG_WR && REG_ADDR == OFS_MAP_60;

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      wr_ctrl[p] = REG_WR && REG_ADDR == OFS_PORT_CTRL[p];
    end
  end

  // dscp map registers, whole byte written at once
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      map52_reg <= RST_MAP;
      map56_reg <= RST_MAP;
      map60_reg <= RST_MAP;
    end else begin
      if (wr_map52) begin
        map52_reg <= REG_WDATA;
      end
      if (wr_map56) begin
        map56_reg <= REG_WDATA;
      end
      if (wr_map60) begin
        map60_reg <= REG_WDATA;
      end
    end
  end

  // per port insert bits; reserved bits are not stored at all
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      ins_reg <= {NUM_PORTS{RST_INS}};
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (wr_ctrl[p]) begin
          ins_reg[p] <= {REG_WDATA[BIT_INS_HIGH],
                         REG_WDATA[BIT_INS_2HIGH],
                         REG_WDATA[BIT_INS_2LOW]};
        end
      end
    end
  end

  // read mux; unmapped and reserved offsets answer zero
  always_comb begin
    rdata_next = 8'h00;
    unique case (REG_ADDR)
      OFS_MAP_52: rdata_next = map52_reg;
      OFS_MAP_56: rdata_next = map56_reg;
      OFS_MAP_60: rdata_next = map60_reg;
      default: rdata_next = 8'h00;
    endcase
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (REG_ADDR == OFS_PORT_CTRL[p]) begin
        rdata_next = {4'h0, ins_reg[p], 1'b0};
      end
    end
  end

  // read data is registered; a read in a write cycle returns the old value
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= RST_RDATA;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= REG_RD;
      if (REG_RD) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign REG_RDATA = rdata_reg;
  assign REG_RVALID = rvalid_reg;

  // configuration handed to the decision units; the global bit is owned
  // by a register elsewhere in the switch, on this same clock
  assign cfg.dscp_upper = {map60_reg, map56_reg, map52_reg};
  assign cfg.ins_en = ins_reg;
  assign cfg.global_en = GLOBAL_PVID_EN;

  // priority lookup shared by ipv4 and ipv6
  dpv_dscp_class u_class (
    .clk(CLOCK),
    .rst_n(rst_n),
    .cfg(cfg.cls),
    .lower_map(LOWER_DSCP_MAP),
    .pkt_valid(PKT_VALID),
    .pkt_tos(PKT_TOS),
    .prio_reg(PKT_PRIO),
    .prio_valid_reg(PKT_PRIO_VALID)
  );

  // egress pvid insertion decision
  dpv_pvid_sel u_pvid (
    .clk(CLOCK),
    .rst_n(rst_n),
    .cfg(cfg.pvid),
    .frm_valid(FRM_VALID),
    .frm_untagged(FRM_UNTAGGED),
    .frm_src(FRM_SRC_PORT),
    .frm_dst(FRM_DST_PORT),
    .insert_reg(FRM_INSERT_PVID),
    .done_reg(FRM_DONE)
  );

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!rst_n);

  a_map52_write: assert property (
    wr_map52 ##1 REG_RD && REG_ADDR == OFS_MAP_52 && !REG_WR
      |=> REG_RVALID && REG_RDATA == $past(REG_WDATA, 2))
    else $error("map 0x9d readback differs from write");

  a_map56_write: assert property (
    wr_map56 |=> map56_reg == $past(REG_WDATA))
    else $error("map 0x9e did not take write");

  a_map60_field: assert property (
    wr_map60 |=> cfg.dscp_upper[23:22] == $past(REG_WDATA[7:6]) &&
      cfg.dscp_upper[17:16] == $past(REG_WDATA[1:0]))
    else $error("map 0x9f fields misplaced");

  a_map_stable: assert property (
    !REG_WR |=> $stable(cfg.dscp_upper) && $stable(ins_reg))
    else $error("registers changed without a write");

  a_ctrl_reserved: assert property (
    REG_RD && (REG_ADDR[3:0] == 4'h0) && REG_ADDR[7:6] == 2'b11
      |=> REG_RVALID && REG_RDATA[7:4] == 4'h0 && !REG_RDATA[0])
    else $error("reserved control bits not zero");

  a_ctrl_readback: assert property (
    wr_ctrl[2] ##1 REG_RD && REG_ADDR == OFS_PORT_CTRL[2] && !REG_WR
      |=> REG_RDATA[3:1] == $past(REG_WDATA[3:1], 2))
    else $error("port 3 control readback differs");

  a_unmapped_zero: assert property (
    REG_RD && REG_ADDR == OFS_RSVD_B0 |=> REG_RDATA == 8'h00)
    else $error("reserved slot not zero");

  a_read_pulse: assert property (
    !REG_RD |=> !REG_RVALID)
    else $error("read valid without a read");

  // each byte lands in its own slice of the upper map; a swapped slice
  // would still read back correctly, so the position is checked as well
  a_map52_slice: assert property (
    wr_map52 |=> cfg.dscp_upper[7:0] == $past(REG_WDATA))
    else $error("map 0x9d slice misplaced");

  a_map56_slice: assert property (
    wr_map56 |=> cfg.dscp_upper[15:8] == $past(REG_WDATA))
    else $error("map 0x9e slice misplaced");

  a_map60_write: assert property (
    wr_map60 |=> map60_reg == $past(REG_WDATA))
    else $error("map 0x9f did not take write");

  // a map byte moves only under its own write strobe
  a_map52_hold: assert property (
    !wr_map52 |=> $stable(map52_reg))
    else $error("map 0x9d changed without its write");

  a_map56_hold: assert property (
    !wr_map56 |=> $stable(map56_reg))
    else $error("map 0x9e changed without its write");

  a_map60_hold: assert property (
    !wr_map60 |=> $stable(map60_reg))
    else $error("map 0x9f changed without its write");

  // every port keeps bits 3..1 of its last write and nothing else
  a_ctrl0_write: assert property (
    wr_ctrl[0] |=> ins_reg[0] == $past(REG_WDATA[3:1]))
    else $error("port 1 control did not take write");

  a_ctrl1_write: assert property (
    wr_ctrl[1] |=> ins_reg[1] == $past(REG_WDATA[3:1]))
    else $error("port 2 control did not take write");

  a_ctrl2_write: assert property (
    wr_ctrl[2] |=> ins_reg[2] == $past(REG_WDATA[3:1]))
    else $error("port 3 control did not take write");

  a_ctrl3_write: assert property (
    wr_ctrl[3] |=> ins_reg[3] == $past(REG_WDATA[3:1]))
    else $error("port 4 control did not take write");

  a_ctrl_hold: assert property (
    wr_ctrl == 4'h0 |=> $stable(ins_reg))
    else $error("control bits changed without a write");

  // reads return the stored byte as it stood at the taking edge
  a_map52_read: assert property (
    REG_RD && REG_ADDR == OFS_MAP_52 |=> REG_RVALID &&
      REG_RDATA == $past(map52_reg))
    else $error("map 0x9d read differs from register");

  a_map56_read: assert property (
    REG_RD && REG_ADDR == OFS_MAP_56 |=> REG_RVALID &&
      REG_RDATA == $past(map56_reg))
    else $error("map 0x9e read differs from register");

  a_map60_read: assert property (
    REG_RD && REG_ADDR == OFS_MAP_60 |=> REG_RVALID &&
      REG_RDATA == $past(map60_reg))
    else $error("map 0x9f read differs from register");

  a_ctrl0_read: assert property (
    REG_RD && REG_ADDR == OFS_PORT_CTRL[0] |=> REG_RVALID &&
      REG_RDATA == {4'h0, $past(ins_reg[0]), 1'b0})
    else $error("port 1 control read differs");

  a_ctrl1_read: assert property (
    REG_RD && REG_ADDR == OFS_PORT_CTRL[1] |=> REG_RVALID &&
      REG_RDATA == {4'h0, $past(ins_reg[1]), 1'b0})
    else $error("port 2 control read differs");

  a_ctrl2_read: assert property (
    REG_RD && REG_ADDR == OFS_PORT_CTRL[2] |=> REG_RVALID &&
      REG_RDATA == {4'h0, $past(ins_reg[2]), 1'b0})
    else $error("port 3 control read differs");

  a_ctrl3_read: assert property (
    REG_RD && REG_ADDR == OFS_PORT_CTRL[3] |=> REG_RVALID &&
      REG_RDATA == {4'h0, $past(ins_reg[3]), 1'b0})
    else $error("port 4 control read differs");

  // read data stands until the next read, so software may poll it late
  a_rdata_hold: assert property (
    !REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved without a read");

endmodule
`default_nettype wire

// >>> tb/dpv_top_tb.sv
// self-checking bench for the dscp map and pvid insert registers
`timescale 1ns/1ps
`default_nettype none
module dpv_top_tb;
  import dpv_pkg::*;

  logic clock;
  logic arst_n;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic global_en;
  logic [103:0] lower_map;
  logic pkt_valid;
  logic [7:0] pkt_tos;
  logic [1:0] pkt_prio;
  logic pkt_prio_valid;
  logic frm_valid;
  logic frm_untagged;
  logic [1:0] frm_src;
  logic [1:0] frm_dst;
  logic frm_insert;
  logic frm_done;
  int n_fail;
  int n_compared;
  // egress per source, rows: highest, second highest, second lowest
  int egress [3][4] = '{'{3, 3, 3, 2}, '{2, 2, 1, 1}, '{1, 0, 0, 0}};

  dpv_top dpv_top_i (
    .CLOCK(clock),
    .ARST_N(arst_n),
    .REG_WR(reg_wr),
    .REG_RD(reg_rd),
    .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata),
    .REG_RVALID(reg_rvalid),
    .GLOBAL_PVID_EN(global_en),
    .LOWER_DSCP_MAP(lower_map),
    .PKT_VALID(pkt_valid),
    .PKT_TOS(pkt_tos),
    .PKT_PRIO(pkt_prio),
    .PKT_PRIO_VALID(pkt_prio_valid),
    .FRM_VALID(frm_valid),
    .FRM_UNTAGGED(frm_untagged),
    .FRM_SRC_PORT(frm_src),
    .FRM_DST_PORT(frm_dst),
    .FRM_INSERT_PVID(frm_insert),
    .FRM_DONE(frm_done)
  );

  // 125 mhz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // single place where the run ends
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  // one write strobe; an idle cycle follows so strobes never merge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // read answers exactly one cycle after the taking edge, for one cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk("read valid", 8'h01, {7'h00, reg_rvalid});
    chk("read data", exp, reg_rdata);
    @(posedge clock);
    #1;
    chk("read valid drop", 8'h00, {7'h00, reg_rvalid});
  endtask

  task automatic classify(input logic [7:0] tos, input logic [1:0] exp);
    @(posedge clock);
    pkt_valid <= 1'b1;
    pkt_tos <= tos;
    @(posedge clock);
    pkt_valid <= 1'b0;
    #1;
    chk("prio valid", 8'h01, {7'h00, pkt_prio_valid});
    chk("prio", {6'h00, exp}, {6'h00, pkt_prio});
  endtask

  task automatic frame(input int src, input int dst, input logic untag,
                       input logic en, input logic exp);
    @(posedge clock);
    frm_valid <= 1'b1;
    frm_untagged <= untag;
    frm_src <= 2'(src);
    frm_dst <= 2'(dst);
    global_en <= en;
    @(posedge clock);
    frm_valid <= 1'b0;
    #1;
    chk("frame done", 8'h01, {7'h00, frm_done});
    chk("insert pvid", {7'h00, exp}, {7'h00, frm_insert});
  endtask

  // every register reads zero straight after reset
  task automatic reset_values;
    logic [7:0] a [7] = '{8'h9d, 8'h9e, 8'h9f, 8'hc0, 8'hd0, 8'he0, 8'hf0};
    for (int i = 0; i < 7; i++) begin
      rd(a[i], 8'h00);
    end
  endtask

  // map registers keep all eight bits; reserved and unmapped read zero
  task automatic map_rw;
    wr(OFS_MAP_52, 8'ha5);
    wr(OFS_MAP_56, 8'h5a);
    wr(OFS_MAP_60, 8'hc3);
    wr(OFS_RSVD_B0, 8'hff);
    wr(8'h00, 8'hff);
    rd(OFS_MAP_52, 8'ha5);
    rd(OFS_MAP_56, 8'h5a);
    rd(OFS_MAP_60, 8'hc3);
    rd(OFS_RSVD_B0, 8'h00);
    rd(8'h00, 8'h00);
  endtask

  // only bits 3..1 of a port control register are writable
  task automatic port_ctrl;
    for (int p = 0; p < 4; p++) begin
      wr(OFS_PORT_CTRL[p], 8'hff);
      rd(OFS_PORT_CTRL[p], 8'h0e);
      wr(OFS_PORT_CTRL[p], 8'hf1);
      rd(OFS_PORT_CTRL[p], 8'h00);
    end
  endtask

  // all 64 code points, low tos bits set to show they are ignored
  task automatic classify_all;
    logic [127:0] full;
    @(posedge clock);
    lower_map <= {13{8'h6c}};
    wr(OFS_MAP_52, 8'he4);
    wr(OFS_MAP_56, 8'h1b);
    wr(OFS_MAP_60, 8'h9c);
    full = {8'h9c, 8'h1b, 8'he4, {13{8'h6c}}};
    for (int cp = 0; cp < 64; cp++) begin
      classify({6'(cp), 2'b11}, full[2*cp +: 2]);
    end
  endtask

  // one insert bit at a time on the source, the rest set on other ports
  task automatic pvid_all;
    logic [7:0] bitv;
    for (int s = 0; s < 4; s++) begin
      for (int b = 0; b < 3; b++) begin
        bitv = 8'h08 >> b;
        for (int p = 0; p < 4; p++) begin
          wr(OFS_PORT_CTRL[p], (p == s) ? bitv : (8'h0e & ~bitv));
        end
        for (int d = 0; d < 4; d++) begin
          frame(s, d, 1'b1, 1'b1, d == egress[b][s]);
        end
        frame(s, egress[b][s], 1'b1, 1'b0, 1'b0);
        frame(s, egress[b][s], 1'b0, 1'b1, 1'b0);
      end
    end
  endtask

  // write and read in one cycle, then a read right behind a write
  task automatic back_to_back;
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_rd <= 1'b1;
    reg_addr <= OFS_MAP_52;
    reg_wdata <= 8'h96;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
    chk("read beside write", 8'he4, reg_rdata);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= OFS_PORT_CTRL[2];
    reg_wdata <= 8'h0a;
    #1;
    chk("read after write", 8'h96, reg_rdata);
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    #1;
    chk("read valid low", 8'h00, {7'h00, reg_rvalid});
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk("port 3 readback", 8'h0a, reg_rdata);
  endtask

  // reset in mid-run clears every written register and insert bit
  task automatic reset_again;
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (8) @(posedge clock);
    chk("rdata in reset", 8'h00, reg_rdata);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    reset_values();
    for (int s = 0; s < 4; s++) begin
      frame(s, egress[0][s], 1'b1, 1'b1, 1'b0);
    end
  endtask

  // main sequence
  initial begin
    n_fail = 0;
    n_compared = 0;
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    global_en = 1'b0;
    lower_map = '0;
    pkt_valid = 1'b0;
    pkt_tos = 8'h00;
    frm_valid = 1'b0;
    frm_untagged = 1'b0;
    frm_src = 2'h0;
    frm_dst = 2'h0;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    // internal reset needs two edges to clear
    repeat (3) @(posedge clock);
    reset_values();
    map_rw();
    port_ctrl();
    classify_all();
    back_to_back();
    pvid_all();
    reset_again();
    conclude();
  end

  // guard against a hung run
  initial begin
    #400000;
    n_fail++;
    $display("[ERR] run length expected done seen timeout");
    conclude();
  end
endmodule
`default_nettype wire
